// file: verilog/tos_defines.vh
// constants for the trip output sequencer
`ifndef TOS_DEFINES_VH
`define TOS_DEFINES_VH
`define TOS_CLK_HZ 125000000
`define TOS_SAMPLE_US 1000
`define TOS_PREP_TIMEOUT_MS 50
`define TOS_SAMPLE_CYC ((`TOS_CLK_HZ / 1000000) * `TOS_SAMPLE_US)
`define TOS_PREP_TIMEOUT_TICKS (`TOS_PREP_TIMEOUT_MS * 1000 / `TOS_SAMPLE_US)
`define TOS_STRETCH_TICKS 100
`define TOS_CH_ST_IDLE 2'b00
`define TOS_CH_ST_PREP 2'b01
`define TOS_CH_ST_FIRE 2'b10
`define TOS_MODE_FAST 2'b00
`define TOS_MODE_USER 2'b01
`define TOS_MODE_FASTL1 2'b10
`define TOS_MODE_SIGNAL 2'b11
`endif

// file: verilog/tos_sample_tick.v
// sampling cycle tick generator, one pulse per sampling period
`include "tos_defines.vh"
module tos_sample_tick #(
	parameter PERIOD = `TOS_SAMPLE_CYC
) (
	input wire clk_i,
	input wire rst_i,
	output reg tick_o
);
	reg [31:0] cnt; // cycles into the current sample period
	// free running divider; tick is registered, so it is high in the first cycle of each period, while cnt is 0
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 32'h0;
			tick_o <= 1'b0;
		end else if (cnt == PERIOD - 1) begin
			cnt <= 32'h0;
			tick_o <= 1'b1;
		end else begin
			cnt <= cnt + 32'h1;
			tick_o <= 1'b0;
		end
	end
endmodule // tos_sample_tick

// file: verilog/tos_trip_logic.v
// trip logic: phase widening and minimum pulse stretch, in sample ticks
`include "tos_defines.vh"
module tos_trip_logic #(
	parameter STRETCH = `TOS_STRETCH_TICKS
) (
	input wire clk_i,
	input wire rst_i,
	input wire tick_i,
	input wire [2:0] phase_req_i,
	input wire three_ph_req_i,
	input wire widen_en_i,
	output reg [2:0] trip_o
);
	reg [15:0] cnt; // ticks left of stretch
	reg [2:0] held; // phases held during stretch
	reg [2:0] want; // widened request
	reg multi; // two or more phases asked
	// a phase-to-phase fault touches two phases, so treat it as three-phase
	always @* begin
		multi = (phase_req_i[0] & phase_req_i[1]) | (phase_req_i[1] & phase_req_i[2])
			| (phase_req_i[0] & phase_req_i[2]);
		want = phase_req_i; // default: pass through
		if (three_ph_req_i | (widen_en_i & multi)) begin
			want = 3'h7;
		end
	end
	// stretch restarts while request stands; only counted on sample ticks
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 16'h0;
			held <= 3'h0;
			trip_o <= 3'h0;
		end else if (tick_i) begin
			if (want != 3'h0) begin
				held <= held | want;
				cnt <= STRETCH[15:0];
				trip_o <= held | want;
			end else if (cnt > 16'h1) begin
				cnt <= cnt - 16'h1;
				trip_o <= held;
			end else begin
				cnt <= 16'h0;
				held <= 3'h0;
				trip_o <= 3'h0;
			end
		end
	end
endmodule // tos_trip_logic

// file: verilog/tos_trip_output_sequencer.v
// trip output sequencer: two-step drive of mechanical contact and fast switch
// Notes on behaviour
// - contact and switch in series per output
// - prepare first, then fire; the code closes both in one step on a protection trip or a direct command
// - threshold violation closes mechanical contact
// - trip decision closes electronic switch
// - preparation without trip reopens after 50 ms
// - fast logic evaluated each 1 ms sample
// - all contact sources ORed per output
// - phase-to-phase request widened to three-phase
// - trip stretched to configurable minimum length
// - sources: protection, scada, panel, binary inputs
// - four modes: fast, user, fast L1, signal
// - only trip logic outputs assignable to trip contacts
`include "tos_defines.vh"
module tos_trip_output_sequencer #(
	parameter N_OUT = 4,
	parameter N_SIG = 4,
	parameter SAMPLE_CYC = `TOS_SAMPLE_CYC,
	parameter PREP_TICKS = `TOS_PREP_TIMEOUT_TICKS,
	parameter STRETCH_TICKS = `TOS_STRETCH_TICKS
) (
	input wire REF_CLK_I,
	input wire SYS_RST_I,
	input wire [N_OUT-1:0] PROT_PICKUP_I,
	input wire [N_OUT-1:0] PROT_TRIP_I,
	input wire [2:0] PHASE_REQ_I,
	input wire THREE_PH_REQ_I,
	input wire WIDEN_EN_I,
	input wire [3*N_OUT-1:0] TRIP_ASSIGN_I,
	input wire [N_OUT-1:0] SCADA_CMD_I,
	input wire [N_OUT-1:0] PANEL_CMD_I,
	input wire [N_OUT-1:0] BIN_IN_I,
	input wire [N_OUT-1:0] FAST_L1_I,
	input wire [N_SIG-1:0] SIG_CMD_I,
	output wire [N_OUT-1:0] MECH_CLOSE_O,
	output wire [N_OUT-1:0] SWITCH_CLOSE_O,
	output wire [N_OUT-1:0] COIL_ON_O,
	output reg [N_SIG-1:0] SIG_RELAY_O,
	output wire [N_OUT-1:0] PREP_TIMEOUT_O
);
	wire tick; // one pulse per sampling cycle
	wire [2:0] tl_trip; // trip logic outputs per phase
	reg [N_OUT-1:0] bin_s1; // pin synchroniser first stage
	reg [N_OUT-1:0] bin_s2; // second stage
	reg [N_OUT-1:0] bin_s3; // third stage
	reg [N_OUT-1:0] bin_q; // qualified binary input level

	tos_sample_tick #(
		.PERIOD(SAMPLE_CYC)
	) u_tick (
		.clk_i(REF_CLK_I),
		.rst_i(SYS_RST_I),
		.tick_o(tick)
	);

	tos_trip_logic #(
		.STRETCH(STRETCH_TICKS)
	) u_trip_logic (
		.clk_i(REF_CLK_I),
		.rst_i(SYS_RST_I),
		.tick_i(tick),
		.phase_req_i(PHASE_REQ_I),
		.three_ph_req_i(THREE_PH_REQ_I),
		.widen_en_i(WIDEN_EN_I),
		.trip_o(tl_trip)
	);

	// binary inputs come from pins; a change counts once stages two and three agree
	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			bin_s1 <= {N_OUT{1'b0}};
			bin_s2 <= {N_OUT{1'b0}};
			bin_s3 <= {N_OUT{1'b0}};
			bin_q <= {N_OUT{1'b0}};
		end else begin
			bin_s1 <= BIN_IN_I;
			bin_s2 <= bin_s1;
			bin_s3 <= bin_s2;
			bin_q <= (bin_s2 & bin_s3) | (bin_q & (bin_s2 | bin_s3));
		end
	end

	// ordinary signal relays: slow path, no sequencing, registered
	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			SIG_RELAY_O <= {N_SIG{1'b0}};
		end else begin
			SIG_RELAY_O <= SIG_CMD_I;
		end
	end

	genvar g;
	generate
		for (g = 0; g < N_OUT; g = g + 1) begin : g_ch
			reg [1:0] state; // idle, prepared or firing
			reg [15:0] prep_cnt; // sample ticks spent in preparation
			reg mech; // mechanical contact drive, one register per channel
			reg swc; // electronic switch drive
			reg tmo; // preparation timeout pulse, one clock long
			wire [2:0] sel; // trip assignment: bit k picks trip logic phase k
			wire tl_hit; // assigned trip logic output active
			wire user_cmd; // user-assigned sources, ORed
			wire direct_cmd; // one-step commands that drive both elements
			assign sel = TRIP_ASSIGN_I[3*g+2:3*g];
			// only trip logic outputs may be assigned, any phase to any contact
			assign tl_hit = |(sel & tl_trip);
			// scada, panel, binary inputs and trip logic share one OR gate
			assign user_cmd = tl_hit | SCADA_CMD_I[g] | PANEL_CMD_I[g] | bin_q[g];
			// fast L1 signals act in a single step, joined to the same OR
			assign direct_cmd = user_cmd | FAST_L1_I[g];

			// fast sequencing is only evaluated on the sampling tick
			// the timeout pulse is cleared every clock so it lasts one cycle only
			always @(posedge REF_CLK_I) begin
				if (SYS_RST_I) begin
					state <= `TOS_CH_ST_IDLE;
					prep_cnt <= 16'h0;
					mech <= 1'b0;
					swc <= 1'b0;
					tmo <= 1'b0;
				end else begin
					tmo <= 1'b0;
					if (tick) begin
						case (state)
							`TOS_CH_ST_IDLE: begin
								prep_cnt <= 16'h0;
								if (direct_cmd | PROT_TRIP_I[g]) begin
									// one-step sources close both at once
									state <= `TOS_CH_ST_FIRE;
									mech <= 1'b1;
									swc <= 1'b1;
								end else if (PROT_PICKUP_I[g]) begin
									state <= `TOS_CH_ST_PREP;
									mech <= 1'b1;
									swc <= 1'b0;
								end else begin
									mech <= 1'b0;
									swc <= 1'b0;
								end
							end
							`TOS_CH_ST_PREP: begin
								if (direct_cmd | PROT_TRIP_I[g]) begin
									state <= `TOS_CH_ST_FIRE;
									swc <= 1'b1;
								end else if (prep_cnt >= PREP_TICKS - 1) begin
									// rattling under test is expected: prep cycles at 50 ms
									state <= `TOS_CH_ST_IDLE;
									mech <= 1'b0;
									tmo <= 1'b1;
								end else begin
									prep_cnt <= prep_cnt + 16'h1;
								end
							end
							`TOS_CH_ST_FIRE: begin
								// holds while a protection trip or direct command stands, not on pickup alone; stretch lives in trip logic
								if (!(direct_cmd | PROT_TRIP_I[g])) begin
									state <= `TOS_CH_ST_IDLE;
									mech <= 1'b0;
									swc <= 1'b0;
								end
							end
							default: begin
								state <= `TOS_CH_ST_IDLE;
								mech <= 1'b0;
								swc <= 1'b0;
							end
						endcase
					end
				end
			end
			// each output bit has exactly one driver, its own channel
			assign MECH_CLOSE_O[g] = mech;
			assign SWITCH_CLOSE_O[g] = swc;
			assign PREP_TIMEOUT_O[g] = tmo;
			// coil current flows only through both series elements
			assign COIL_ON_O[g] = MECH_CLOSE_O[g] & SWITCH_CLOSE_O[g];
		end
	endgenerate
endmodule // tos_trip_output_sequencer

// file: tb/tos_properties.sv
// port assertions for the sequencer, written for a sample period of 10 cycles
module tos_checker #(parameter N_OUT = 4, parameter N_SIG = 4) (
	input wire REF_CLK_I,
	input wire SYS_RST_I,
	input wire [N_OUT-1:0] SCADA_CMD_I,
	input wire [N_SIG-1:0] SIG_CMD_I,
	input wire [N_OUT-1:0] MECH_CLOSE_O,
	input wire [N_OUT-1:0] SWITCH_CLOSE_O,
	input wire [N_OUT-1:0] COIL_ON_O,
	input wire [N_SIG-1:0] SIG_RELAY_O,
	input wire [N_OUT-1:0] PREP_TIMEOUT_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	property p_coil; COIL_ON_O == (MECH_CLOSE_O & SWITCH_CLOSE_O); endproperty
	a_coil: assert property (p_coil) else $error("coil mismatch");
	property p_ord; (SWITCH_CLOSE_O & ~MECH_CLOSE_O) == 0; endproperty
	a_ord: assert property (p_ord) else $error("switch without contact");
	property p_idle; $fell(SYS_RST_I) |-> (MECH_CLOSE_O | SWITCH_CLOSE_O) == 0; endproperty
	a_idle: assert property (p_idle) else $error("not idle after reset");
	property p_sig; !$past(SYS_RST_I) |-> SIG_RELAY_O == $past(SIG_CMD_I); endproperty
	a_sig: assert property (p_sig) else $error("signal relay lag");
	property p_tmo; PREP_TIMEOUT_O[0] |-> !MECH_CLOSE_O[0] ##1 !PREP_TIMEOUT_O[0]; endproperty
	a_tmo: assert property (p_tmo) else $error("timeout pulse");
	property p_tsrc; $rose(PREP_TIMEOUT_O[0]) |-> $past(MECH_CLOSE_O[0]); endproperty
	a_tsrc: assert property (p_tsrc) else $error("timeout without prep");
	// mechanical contact outputs only move once per sample period
	property p_tick; $changed(MECH_CLOSE_O) |=> $stable(MECH_CLOSE_O) [*8]; endproperty
	a_tick: assert property (p_tick) else $error("contact moved between ticks");
	property p_or; SCADA_CMD_I[0] [*8] ##1 SCADA_CMD_I[0] [*4] |-> COIL_ON_O[0]; endproperty
	a_or: assert property (p_or) else $error("scada ignored");
endmodule // tos_checker
bind tos_trip_output_sequencer tos_checker #(.N_OUT(N_OUT), .N_SIG(N_SIG)) tos_checker_i (
	.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .SCADA_CMD_I(SCADA_CMD_I),
	.SIG_CMD_I(SIG_CMD_I), .MECH_CLOSE_O(MECH_CLOSE_O), .SWITCH_CLOSE_O(SWITCH_CLOSE_O),
	.COIL_ON_O(COIL_ON_O), .SIG_RELAY_O(SIG_RELAY_O), .PREP_TIMEOUT_O(PREP_TIMEOUT_O));

// file: tb/tos_breaker_model.sv
// breaker model: opens once its coil has carried current for OPEN_CYC cycles
module tos_breaker_model #(parameter OPEN_CYC = 5) (
	input wire clk_i,
	input wire rst_i,
	input wire coil_i,
	output reg open_o
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [7:0] cnt; // coil current cycles, wraps harmlessly once open
	// current flows only through the series path, so open needs both shut
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 8'h00;
			open_o <= 1'b0;
		end else if (coil_i) begin
			cnt <= cnt + 8'h01;
			open_o <= open_o | (cnt >= OPEN_CYC - 1);
		end
	end
endmodule // tos_breaker_model

// file: tb/tb.sv
// self-checking bench for the trip output sequencer
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [3:0] pick = 4'h0, trip = 4'h0, scada = 4'h0, panel = 4'h0, bin = 4'h0, fl1 = 4'h0;
	reg [3:0] sig = 4'h0; // signal relay commands
	reg [2:0] ph = 3'h0;
	reg three = 1'b0, wid = 1'b0;
	reg [11:0] asg = 12'h000; // phase mask per output
	wire [3:0] mech, sw, coil, sigo, tmo;
	wire opn; // breaker has tripped
	logic [3:0] e; // coil pattern expected while a trip logic request stands
	int miscompares = 0, checked = 0, k, i, s;
	always #4 clk = ~clk;
	// sample period cut to 10 cycles, stretch to 3 ticks, to keep the run short
	tos_trip_output_sequencer #(.SAMPLE_CYC(10), .PREP_TICKS(50), .STRETCH_TICKS(3))
	tos_trip_output_sequencer_i (.REF_CLK_I(clk), .SYS_RST_I(rst), .PROT_PICKUP_I(pick),
		.PROT_TRIP_I(trip), .PHASE_REQ_I(ph), .THREE_PH_REQ_I(three), .WIDEN_EN_I(wid),
		.TRIP_ASSIGN_I(asg), .SCADA_CMD_I(scada), .PANEL_CMD_I(panel), .BIN_IN_I(bin),
		.FAST_L1_I(fl1), .SIG_CMD_I(sig), .MECH_CLOSE_O(mech), .SWITCH_CLOSE_O(sw),
		.COIL_ON_O(coil), .SIG_RELAY_O(sigo), .PREP_TIMEOUT_O(tmo));
	tos_breaker_model #(.OPEN_CYC(5)) tos_breaker_model_i (.clk_i(clk), .rst_i(rst),
		.coil_i(coil[0]), .open_o(opn));
	// widening forces all phases; each output ORs its assigned phases
	function automatic logic [3:0] exp_tl(input [2:0] p, input t, input w, input [11:0] a);
		int g;
		logic [2:0] f;
		f = (t || (w && $countones(p) > 1)) ? 3'h7 : p;
		for (g = 0; g < 4; g++) exp_tl[g] = |(a[3*g +: 3] & f);
	endfunction
	// settle at the falling edge so registered outputs have landed
	task wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wrap_up;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		s = $urandom(22812);
		s = $urandom % 16;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		wt(0);
		chk("reset", {mech, sw, tmo}, 12'h000);
		// preparation alone: contact shuts, switch open, gives up after 50 ticks
		@(posedge clk) pick <= 4'h1;
		wt(25);
		chk("prep", {mech, sw}, 8'h10);
		for (k = 0; k < 700 && tmo[0] !== 1'b1; k++) wt(0);
		if (k == 700) begin
			miscompares++;
			wrap_up;
		end
		chk("prep time", k > 469 && k < 491, 1'b1);
		chk("prep drop", mech[0], 1'b0);
		@(posedge clk) trip <= 4'h1;
		wt(18);
		chk("fire", {mech[0], sw[0], coil[0], opn}, 4'hf);
		@(posedge clk) {pick, trip} <= 8'h00;
		wt(12);
		chk("release", {mech, sw}, 8'h00);
		$display("test prepare and fire done");
		// scada, panel, binary input and fast L1 sources on every output, in a seeded order
		for (i = 0; i < 16; i++) begin
			k = (i + s) % 16;
			@(posedge clk) {fl1, bin, panel, scada} <= 16'h1 << k;
			wt(25);
			chk("or source", coil, 4'h1 << k % 4);
			@(posedge clk) {fl1, bin, panel, scada} <= 16'h0;
			wt(25);
			chk("or idle", coil, 4'h0);
		end
		$display("test sources done");
		// trip logic requests: first a widened two-phase case, then random
		for (i = 0; i < 10; i++) begin
			@(posedge clk) {three, wid, ph, asg} <= (i == 0) ? 17'h0b004 : 17'($urandom);
			wt(25);
			e = exp_tl(ph, three, wid, asg);
			chk("trip logic", coil, e);
			@(posedge clk) {three, ph} <= 4'h0;
			wt(15);
			chk("stretch", coil, exp_tl(3'h0, 1'b1, wid, asg) & coil);
			chk("stretch held", coil, e);
			wt(50);
			chk("stretch end", coil, 4'h0);
		end
		$display("test trip logic done");
		for (i = 0; i < 4; i++) begin
			@(posedge clk) sig <= 4'($urandom);
			wt(1);
			chk("signal relay", sigo, sig);
		end
		$display("test signal relays done");
		wrap_up;
	end
endmodule // tb
